// ==== src/pan_activity_nmi.sv ====
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module pan_activity_nmi
  import pan_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire pan_cycle_t  bus_cycle,
  input  wire pan_events_t events_in,
  output logic             nmi_request,
  output logic             activity_trigger,
  output logic             resume_request,
  output logic [1:0]       power_state
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  pan_events_t ev_meta;
  pan_events_t ev_sync;
  pan_events_t ev_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_meta <= '0;
      ev_sync <= '0;
      ev_prev <= '0;
    end else begin
      ev_meta <= events_in;
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] activity_source_mask;
  logic [7:0] nmi_source_mask;
  logic [7:0] watched_io_range;
  logic [7:0] pending;
  logic       activity_status;
  pan_state_t state;

  wire        access     = psel && penable;
  wire        wr         = access && pwrite;
  wire        hit_status = (paddr == ADDR_STATUS);
  wire        hit_act    = (paddr == ADDR_ACTIVITY_MASK);
  wire        hit_nmi    = (paddr == ADDR_NMI_MASK);
  wire        hit_rng    = (paddr == ADDR_IO_RANGE);
  wire        hit_evt    = (paddr == ADDR_EVENT_STATUS);
  wire        hit_any    = hit_status | hit_act | hit_nmi | hit_rng | hit_evt;
  wire [7:0]  wbyte      = pwdata[7:0];

  // ------------------------------------------------------------
  // activity decode
  // ------------------------------------------------------------
  wire [9:0]  io_addr   = bus_cycle.address[9:0];
  wire        io_cyc    = bus_cycle.valid && bus_cycle.is_io;
  wire        in_disk   = (io_addr >= DISK_LO && io_addr <= DISK_HI) ||
                          (io_addr >= DISK_ALT_LO && io_addr <= DISK_ALT_HI);
  wire        in_serial = (io_addr >= SER_A_LO && io_addr <= SER_A_HI) ||
                          (io_addr >= SER_B_LO && io_addr <= SER_B_HI) ||
                          (io_addr >= SER_C_LO && io_addr <= SER_C_HI);
  wire        in_video  = (bus_cycle.address >= VID_A_LO && bus_cycle.address <= VID_A_HI) ||
                          (bus_cycle.address >= VID_B_LO && bus_cycle.address <= VID_B_HI);
  wire        small_win = watched_io_range[7];
  // start bit 0 ignored for 16 bytes
  wire [6:0]  cmp_mask  = small_win ? 7'h7F : 7'h7E;
  wire        in_range  = ((io_addr[9:3] ^ watched_io_range[6:0]) & cmp_mask) == 7'h00;

  wire        t_disk   = io_cyc && in_disk && !activity_source_mask[ACT_DISK];
  wire        t_serial = io_cyc && in_serial && !activity_source_mask[ACT_SERIAL];
  wire        t_card   = ev_sync.card_access && !activity_source_mask[ACT_CARD];
  wire        t_kbd    = io_cyc && (io_addr == KBD_ADDR) &&
                         !activity_source_mask[ACT_KEYBOARD];
  wire        t_cs     = ev_sync.chip_select && !activity_source_mask[ACT_CHIP_SELECT];
  wire        t_range  = io_cyc && in_range && !activity_source_mask[ACT_RANGE];
  wire        t_video  = bus_cycle.valid && !bus_cycle.is_io && bus_cycle.is_write &&
                         in_video && !activity_source_mask[ACT_VIDEO];
  wire        trigger  = t_disk | t_serial | t_card | t_kbd | t_cs | t_range | t_video;

  // ------------------------------------------------------------
  // nmi sources
  // ------------------------------------------------------------
  wire rise_aux  = ev_sync.aux_event_input && !ev_prev.aux_event_input;
  wire rise_lb1  = ev_sync.primary_low_battery && !ev_prev.primary_low_battery;
  wire rise_lb2  = ev_sync.secondary_low_battery && !ev_prev.secondary_low_battery;
  wire rise_susp = ev_sync.suspend_expired && !ev_prev.suspend_expired;
  wire rise_slp  = ev_sync.sleep_expired && !ev_prev.sleep_expired;
  wire slp_masked = nmi_source_mask[NMI_SLEEP];

  wire [7:0] new_events;
  assign new_events[NMI_GLOBAL]    = 1'b0;
  assign new_events[6]             = 1'b0;
  assign new_events[0]             = 1'b0;
  assign new_events[NMI_AUX]       = rise_aux;
  assign new_events[NMI_PRIMARY]   = rise_lb1;
  assign new_events[NMI_SECONDARY] = rise_lb2;
  assign new_events[NMI_SUSPEND]   = rise_susp;
  // sleep timer in doze or activity in sleep
  assign new_events[NMI_SLEEP]     = (rise_slp && state == PAN_DOZE) ||
                                     (trigger && state == PAN_SLEEP);

  // set wins over software clear (write 1 to clear)
  wire [7:0] clr_events = (wr && hit_evt) ? (wbyte & NMI_SOURCE_BITS) : 8'h00;
  wire [7:0] next_pending = (pending & ~clr_events) | new_events;

  wire       next_nmi = (|(pending & ~nmi_source_mask & NMI_SOURCE_BITS)) &&
                        !nmi_source_mask[NMI_GLOBAL];

  // resume on aux edge regardless of masks
  wire       next_resume = rise_aux && (state == PAN_SUSPEND);

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  pan_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      PAN_ON:      next_state = PAN_ON;
      PAN_DOZE:    if (rise_slp && slp_masked) next_state = PAN_SLEEP;
      PAN_SLEEP:   if (trigger && slp_masked) next_state = PAN_ON;
      PAN_SUSPEND: if (rise_aux) next_state = PAN_ON;
      default:     next_state = PAN_ON;
    endcase
    if (wr && hit_status) begin
      next_state = pan_state_t'(wbyte[1:0]);
    end
  end

  // activity set wins over zero write
  wire next_activity = trigger ||
                       (activity_status && !(wr && hit_status && !wbyte[ST_ACTIVITY]));

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      activity_source_mask <= RST_ACTIVITY_MASK;
      nmi_source_mask      <= RST_NMI_MASK;
      watched_io_range     <= RST_IO_RANGE;
    end else if (wr) begin
      if (hit_act) activity_source_mask <= wbyte & 8'hEF;
      if (hit_nmi) nmi_source_mask      <= wbyte & NMI_SOURCE_BITS | (wbyte & 8'h80);
      if (hit_rng) watched_io_range     <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending          <= 8'h00;
      activity_status  <= 1'b0;
      state            <= PAN_ON;
      nmi_request      <= 1'b0;
      activity_trigger <= 1'b0;
      resume_request   <= 1'b0;
      power_state      <= 2'b00;
    end else begin
      pending          <= next_pending;
      activity_status  <= next_activity;
      state            <= next_state;
      nmi_request      <= next_nmi;
      activity_trigger <= trigger;
      resume_request   <= next_resume;
      power_state      <= next_state;
    end
  end

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_status) rd_byte = {3'h0, activity_status, ev_sync.secondary_low_battery,
                               ev_sync.primary_low_battery, state};
    if (hit_act)    rd_byte = activity_source_mask;
    if (hit_nmi)    rd_byte = nmi_source_mask;
    if (hit_rng)    rd_byte = watched_io_range;
    if (hit_evt)    rd_byte = pending;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      pslverr <= psel && !penable && !hit_any;
    end
  end

endmodule : pan_activity_nmi

// ==== src/pan_pkg.sv ====
package pan_pkg;

  // ------------------------------------------------------------
  // register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0]  IDX_STATUS          = 8'hC0;
  localparam logic [7:0]  IDX_ACTIVITY_MASK   = 8'hC3;
  localparam logic [7:0]  IDX_NMI_MASK        = 8'hC4;
  localparam logic [7:0]  IDX_IO_RANGE        = 8'hC5;
  localparam logic [7:0]  IDX_EVENT_STATUS    = 8'hDC;
  localparam logic [11:0] ADDR_STATUS         = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_ACTIVITY_MASK  = {2'h0, IDX_ACTIVITY_MASK, 2'h0};
  localparam logic [11:0] ADDR_NMI_MASK       = {2'h0, IDX_NMI_MASK, 2'h0};
  localparam logic [11:0] ADDR_IO_RANGE       = {2'h0, IDX_IO_RANGE, 2'h0};
  localparam logic [11:0] ADDR_EVENT_STATUS   = {2'h0, IDX_EVENT_STATUS, 2'h0};

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ACTIVITY_MASK = 8'h80;
  localparam logic [7:0] RST_NMI_MASK      = 8'hBE;
  localparam logic [7:0] RST_IO_RANGE      = 8'h00;

  // ------------------------------------------------------------
  // activity mask bits
  // ------------------------------------------------------------
  localparam int ACT_CHIP_SELECT = 0;
  localparam int ACT_KEYBOARD    = 1;
  localparam int ACT_CARD        = 2;
  localparam int ACT_SERIAL      = 3;
  localparam int ACT_DISK        = 5;
  localparam int ACT_VIDEO       = 6;
  localparam int ACT_RANGE       = 7;

  // ------------------------------------------------------------
  // nmi mask and event status bits
  // ------------------------------------------------------------
  localparam int NMI_AUX       = 1;
  localparam int NMI_PRIMARY   = 2;
  localparam int NMI_SECONDARY = 3;
  localparam int NMI_SLEEP     = 4;
  localparam int NMI_SUSPEND   = 5;
  localparam int NMI_GLOBAL    = 7;
  localparam logic [7:0] NMI_SOURCE_BITS = 8'h3E;

  // ------------------------------------------------------------
  // status register fields
  // ------------------------------------------------------------
  localparam int ST_ACTIVITY = 4;
  localparam int ST_LB2      = 3;
  localparam int ST_LB1      = 2;

  // ------------------------------------------------------------
  // watched address ranges
  // ------------------------------------------------------------
  localparam logic [9:0]  DISK_LO    = 10'h1F0;
  localparam logic [9:0]  DISK_HI    = 10'h1F7;
  localparam logic [9:0]  DISK_ALT_LO = 10'h3F6;
  localparam logic [9:0]  DISK_ALT_HI = 10'h3F7;
  localparam logic [9:0]  SER_A_LO   = 10'h2E8;
  localparam logic [9:0]  SER_A_HI   = 10'h2EF;
  localparam logic [9:0]  SER_B_LO   = 10'h2F8;
  localparam logic [9:0]  SER_B_HI   = 10'h2FF;
  localparam logic [9:0]  SER_C_LO   = 10'h3F8;
  localparam logic [9:0]  SER_C_HI   = 10'h3FF;
  localparam logic [9:0]  KBD_ADDR   = 10'h060;
  localparam logic [19:0] VID_A_LO   = 20'hA0000;
  localparam logic [19:0] VID_A_HI   = 20'hAFFFF;
  localparam logic [19:0] VID_B_LO   = 20'hB8000;
  localparam logic [19:0] VID_B_HI   = 20'hBFFFF;

  // ------------------------------------------------------------
  // power states and carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PAN_ON      = 2'b00,
    PAN_DOZE    = 2'b01,
    PAN_SLEEP   = 2'b10,
    PAN_SUSPEND = 2'b11
  } pan_state_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        is_write;
    logic [19:0] address;
  } pan_cycle_t;

  typedef struct packed {
    logic card_access;
    logic chip_select;
    logic suspend_expired;
    logic sleep_expired;
    logic primary_low_battery;
    logic secondary_low_battery;
    logic aux_event_input;
  } pan_events_t;

endpackage : pan_pkg

// ==== tb/pan_sysbus_model.sv ====
`timescale 1ns/100ps
module pan_sysbus_model
  import pan_pkg::*;
(
  input  wire logic   pclk,
  output pan_cycle_t  bus_cycle,
  output pan_events_t events_in
);
  // ----------------------------------------
  // bus cycles and event pins
  // ----------------------------------------
  initial begin
    bus_cycle = '0;
    events_in = '0;
  end

  // one valid cycle, then the address lines flip while idle
  task access(input logic io, input logic w, input logic [19:0] a);
    @(posedge pclk);
    bus_cycle <= '{1'b1, io, w, a};
    @(posedge pclk);
    bus_cycle <= '{1'b0, io, w, ~a};
  endtask : access

  task set_ev(input int b, input logic v);
    @(posedge pclk);
    events_in[b] <= v;
  endtask : set_ev
endmodule : pan_sysbus_model

// ==== tb/pan_asserts.sv ====
`timescale 1ns/100ps
module pan_asserts
  import pan_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire pan_cycle_t  bus_cycle,
  input wire pan_events_t events_in,
  input wire logic        nmi_request,
  input wire logic        activity_trigger,
  input wire logic        resume_request,
  input wire logic [1:0]  power_state
);
  // ----------------------------------------
  // shadow of written masks
  // ----------------------------------------
  logic [7:0] sh_act;
  logic [7:0] sh_nmi;
  logic [7:0] sh_rng;
  logic       wr_acc;
  logic       io_v;
  logic       mapped;
  logic [9:0] sa;
  assign wr_acc = psel & penable & pwrite & pready;
  assign io_v = bus_cycle.valid & bus_cycle.is_io;
  assign sa = bus_cycle.address[9:0];
  assign mapped = paddr inside {ADDR_STATUS, ADDR_ACTIVITY_MASK, ADDR_NMI_MASK,
                                ADDR_IO_RANGE, ADDR_EVENT_STATUS};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_act <= RST_ACTIVITY_MASK;
      sh_nmi <= RST_NMI_MASK;
      sh_rng <= RST_IO_RANGE;
    end else if (wr_acc) begin
      if (paddr == ADDR_ACTIVITY_MASK) sh_act <= pwdata[7:0];
      if (paddr == ADDR_NMI_MASK) sh_nmi <= pwdata[7:0];
      if (paddr == ADDR_IO_RANGE) sh_rng <= pwdata[7:0];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  slave_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  disk_trig_a: assert property (io_v && !sh_act[ACT_DISK] && ((sa >= DISK_LO &&
    sa <= DISK_HI) || (sa >= DISK_ALT_LO && sa <= DISK_ALT_HI)) |=> activity_trigger)
    else $error("disk access gave no trigger");
  serial_trig_a: assert property (io_v && !sh_act[ACT_SERIAL] && (sa[9:3] == 7'h5D ||
    sa[9:3] == 7'h5F || sa[9:3] == 7'h7F) |=> activity_trigger)
    else $error("serial access gave no trigger");
  kbd_trig_a: assert property (io_v && !sh_act[ACT_KEYBOARD] && sa == KBD_ADDR
    |=> activity_trigger) else $error("keyboard access gave no trigger");
  video_trig_a: assert property (bus_cycle.valid && !bus_cycle.is_io &&
    bus_cycle.is_write && !sh_act[ACT_VIDEO] && bus_cycle.address[19:16] == 4'hA
    |=> activity_trigger) else $error("video write gave no trigger");
  range_trig_a: assert property (io_v && !sh_act[ACT_RANGE] && (sh_rng[7] ?
    sa[9:3] == sh_rng[6:0] : sa[9:4] == sh_rng[6:1]) |=> activity_trigger)
    else $error("range match gave no trigger");
  global_block_a: assert property (sh_nmi[NMI_GLOBAL] && $past(sh_nmi[NMI_GLOBAL])
    |-> !nmi_request) else $error("nmi under global mask");
  src_mask_a: assert property (sh_nmi[5:1] == 5'h1F && $past(sh_nmi[5:1]) == 5'h1F
    |-> !nmi_request) else $error("nmi from masked sources");
  aux_nmi_a: assert property ($rose(events_in.aux_event_input) && !sh_nmi[NMI_AUX]
    && !sh_nmi[NMI_GLOBAL] |-> ##[3:6] nmi_request) else $error("aux rise gave no nmi");
  suspend_cmd_a: assert property ($rose(power_state == PAN_SUSPEND)
    |-> $past(wr_acc && paddr == ADDR_STATUS && pwdata[1:0] == 2'b11))
    else $error("suspend without command");
endmodule : pan_asserts

bind pan_activity_nmi pan_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .bus_cycle(bus_cycle), .events_in(events_in),
  .nmi_request(nmi_request), .activity_trigger(activity_trigger),
  .resume_request(resume_request), .power_state(power_state));

// ==== tb/pan_activity_nmi_tb.sv ====
`timescale 1ns/100ps
module pan_activity_nmi_tb;
  import pan_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, nmi_request, activity_trigger, resume_request, err, seen;
  logic [1:0]  power_state;
  pan_cycle_t  bus_cycle;
  pan_events_t events_in;
  int          failures = 0, comparisons = 0, cyc = 0;
  int          nb[4] = '{1, 2, 3, 5};
  int          eb[4] = '{0, 2, 1, 4};
  logic [19:0] hit[8] = '{20'h1F0, 20'h1F7, 20'h3F6, 20'h3F7, 20'h2E8, 20'h2FF, 20'h3F8, 20'h060};
  logic [19:0] miss[6] = '{20'h1EF, 20'h1F8, 20'h3F5, 20'h2E7, 20'h2F0, 20'h061};
  logic [7:0]  m;

  always #2.5 pclk = ~pclk;
  pan_sysbus_model model (.pclk(pclk), .bus_cycle(bus_cycle), .events_in(events_in));
  pan_activity_nmi DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bus_cycle(bus_cycle), .events_in(events_in),
    .nmi_request(nmi_request), .activity_trigger(activity_trigger),
    .resume_request(resume_request), .power_state(power_state));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h0, d});
  endtask : wr

  task rdc(input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 0);
    check(rd, {24'h0, e});
  endtask : rdc

  // s: 0 trigger, 1 nmi, 2 resume
  task watch(input int n, input int s);
    seen = 0;
    repeat (n) begin
      @(negedge pclk);
      seen = seen | (s == 0 ? activity_trigger : s == 1 ? nmi_request : resume_request);
    end
  endtask : watch

  task bus(input logic io, input logic w, input logic [19:0] a, input logic e);
    model.access(io, w, a);
    watch(3, 0);
    check(seen, e);
  endtask : bus

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      end_of_test;
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdc(ADDR_ACTIVITY_MASK, 8'h80);
    rdc(ADDR_NMI_MASK, 8'hBE);
    rdc(ADDR_IO_RANGE, 8'h00);
    apb(0, 12'hFFC, 0);
    check(err, 1);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_ACTIVITY_MASK, k ? 8'hFF : 8'h00);
      foreach (hit[i]) bus(1, 0, hit[i], !k);
      for (int e = 5; e < 7; e++) begin
        model.set_ev(e, 1);
        watch(8, 0);
        check(seen, !k);
        model.set_ev(e, 0);
      end
      bus(0, 1, 20'hA0000, !k);
      bus(0, 1, 20'hBFFFF, !k);
    end
    rdc(ADDR_STATUS, 8'h10);
    wr(ADDR_STATUS, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
    wr(ADDR_ACTIVITY_MASK, 8'h00);
    foreach (miss[i]) bus(1, 0, miss[i], 0);
    bus(0, 1, 20'hB7FFF, 0);
    bus(0, 0, 20'hB8000, 0);
    wr(ADDR_ACTIVITY_MASK, 8'h7F);
    wr(ADDR_IO_RANGE, 8'hD5);
    bus(1, 0, 20'h2A8, 1);
    bus(1, 0, 20'h2A7, 0);
    wr(ADDR_IO_RANGE, 8'h55);
    bus(1, 0, 20'h2A0, 1);
    bus(1, 0, 20'h2AF, 1);
    bus(1, 0, 20'h2B0, 0);
    wr(ADDR_ACTIVITY_MASK, 8'hFF);
    bus(1, 0, 20'h2A0, 0);
    for (int i = 0; i < 4; i++) begin
      m = 8'h3E & ~(8'h01 << nb[i]);
      wr(ADDR_NMI_MASK, m);
      model.set_ev(eb[i], 1);
      watch(8, 1);
      check(seen, 1);
      model.set_ev(eb[i], 0);
      wr(ADDR_EVENT_STATUS, 8'h01 << nb[i]);
      watch(2, 1);
      check(nmi_request, 0);
      wr(ADDR_NMI_MASK, m | 8'h80);
      model.set_ev(eb[i], 1);
      watch(8, 1);
      check(seen, 0);
      rdc(ADDR_EVENT_STATUS, 8'h01 << nb[i]);
      wr(ADDR_NMI_MASK, m);
      watch(3, 1);
      check(seen, 1);
      wr(ADDR_EVENT_STATUS, 8'h01 << nb[i]);
      model.set_ev(eb[i], 0);
      wr(ADDR_NMI_MASK, 8'h3E);
      model.set_ev(eb[i], 1);
      watch(8, 1);
      check(seen, 0);
      model.set_ev(eb[i], 0);
      wr(ADDR_EVENT_STATUS, 8'h3E);
    end
    check(power_state, 0);
    wr(ADDR_ACTIVITY_MASK, 8'h00);
    wr(ADDR_STATUS, 8'h01);
    model.set_ev(3, 1);
    watch(8, 1);
    check(power_state, 2);
    model.set_ev(3, 0);
    bus(1, 0, 20'h060, 1);
    check(power_state, 0);
    wr(ADDR_NMI_MASK, 8'h2E);
    wr(ADDR_STATUS, 8'h01);
    model.set_ev(3, 1);
    watch(8, 1);
    check({seen, power_state}, 3'h5);
    model.set_ev(3, 0);
    wr(ADDR_EVENT_STATUS, 8'h3E);
    wr(ADDR_STATUS, 8'h02);
    model.access(1, 0, 20'h060);
    watch(6, 1);
    check({seen, power_state}, 3'h6);
    wr(ADDR_EVENT_STATUS, 8'h3E);
    wr(ADDR_NMI_MASK, 8'hBE);
    wr(ADDR_STATUS, 8'h03);
    @(negedge pclk);
    check(power_state, 3);
    model.set_ev(0, 1);
    watch(8, 2);
    check({seen, power_state}, 3'h4);
    model.set_ev(0, 0);
    end_of_test;
  end
endmodule : pan_activity_nmi_tb
